// ---- wkp_wake_ctrl.sv ----
// Wake event collection, button pass-through, power-loss restore and kbd/mouse wake.
// Contract
// - Global wake enable at zero keeps the wake event output inactive.
// - Each source latches its status; writing one clears it.
// - Wake output needs a source with both status and enable set.
// - Nine sources: mouse, keyboard, pin41, infrared, UART, IR, monitor, watchdog, ring.
// - All sources work in S0/S1; first four also in S3 to S5.
// - Button output follows button input low for as long as held.
// - Two-bit policy: off, on, restore previous, or software-defined state; used only in the first cycle after reset, when it still holds off.
// - Previous state sampled from sleep S3 as main supply collapses.
// - Software-defined policy bit: zero powers on, one stays off.
// - Qualifying keyboard or mouse wake emits one low button pulse.
// - Keyboard wake only while keyboard wake enable is one.
// - Mode bit one wakes on any key, zero on stored password.
// - Three password sets at 00-0E, 30-3E, 40-4E via index and data.
// - Each key is make code then break code F0 plus make.
// - Mouse wake only while mouse wake enable is one.
// - Motion, single and right select bits choose the mouse event.
//
// Chosen here: the placing of the registers and the AHB-Lite register port.
`default_nettype none

module wkp_wake_ctrl
	import wkp_pkg::*;
(
	input  wire logic                hclk,
	input  wire logic                hresetn,
	input  wire logic                hsel,
	input  wire logic [31:0]         haddr,
	input  wire logic [1:0]          htrans,
	input  wire logic                hwrite,
	input  wire logic [2:0]          hsize,
	input  wire logic [31:0]         hwdata,
	input  wire logic                hready,
	output logic                     hreadyout,
	output logic                     hresp,
	output var  logic [31:0]         hrdata,
	input  wire logic [WKP_NSRC-1:0] src_event,
	input  wire logic                deep_sleep,
	input  wire logic                kbd_valid,
	input  wire logic [7:0]          kbd_byte,
	input  wire logic                mouse_valid,
	input  wire logic [7:0]          mouse_byte,
	input  wire logic                button_in_n,
	input  wire logic                sleep_s3_n,
	input  wire logic                main_supply_3v,
	output logic                     button_out_n,
	output var  logic                supply_on_n,
	output logic                     wake_event_out_n,
	output logic                     irq
);
	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	// Reset to the idle pin levels, so no false edge or supply glitch follows reset.
	localparam logic [WKP_NSRC+3:0] SYNC_IDLE = {4'h1, {WKP_NSRC{1'b0}}};
	logic [WKP_NSRC+3:0] meta_q, sync_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta_q <= SYNC_IDLE;
			sync_q <= SYNC_IDLE;
		end else begin
			meta_q <= {deep_sleep, main_supply_3v, sleep_s3_n, button_in_n, src_event};
			sync_q <= meta_q;
		end
	end
	wire [WKP_NSRC-1:0] src_s    = sync_q[WKP_NSRC-1:0];
	wire                btn_s_n  = sync_q[WKP_NSRC];
	wire                s3_s_n   = sync_q[WKP_NSRC+1];
	wire                vcc_s    = sync_q[WKP_NSRC+2];
	wire                deep_s   = sync_q[WKP_NSRC+3];

	// ----------------------------------------------------------------
	// AHB-Lite slave
	// ----------------------------------------------------------------
	logic       wr_q, rd_q;
	logic [7:0] addr_q;
	wire        take   = hsel && hready && htrans[1];
	wire        wr_en  = wr_q;
	wire        wr_gl  = wr_en && (addr_q == WKP_GLOBAL_EN_ADDR);
	wire        wr_st  = wr_en && (addr_q == WKP_STATUS_ADDR);
	wire        wr_en_r= wr_en && (addr_q == WKP_ENABLE_ADDR);
	wire        wr_km  = wr_en && (addr_q == WKP_KBMS_CFG_ADDR);
	wire        wr_pc  = wr_en && (addr_q == WKP_POWER_CFG_ADDR);
	wire        wr_pi  = wr_en && (addr_q == WKP_PW_INDEX_ADDR);
	wire        wr_pd  = wr_en && (addr_q == WKP_PW_DATA_ADDR);
	// Password data is fetched during the address phase; the registered memory
	// output then costs one wait state before hrdata can carry it.
	wire        pd_take = take && !hwrite && (haddr[7:0] == WKP_PW_DATA_ADDR);
	wire        rd_pd  = rd_q && (addr_q == WKP_PW_DATA_ADDR);
	logic       wait_q;
	assign hreadyout = !(rd_pd && !wait_q);
	assign hresp     = 1'b0;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q   <= 1'b0;
			rd_q   <= 1'b0;
			addr_q <= 8'h00;
			wait_q <= 1'b0;
		end else begin
			wait_q <= rd_pd && !wait_q;
			if (hreadyout) begin
				wr_q   <= take && hwrite;
				rd_q   <= take && !hwrite;
				addr_q <= haddr[7:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	logic                glob_en_q;
	logic [WKP_NSRC-1:0] stat_q, en_q;
	logic [7:0]          kbms_q, pwr_q;
	logic [6:0]          pw_idx_q;
	logic                prev_on_q, vcc_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			glob_en_q <= 1'b0;
			en_q      <= '0;
			kbms_q    <= WKP_KBMS_CFG_RST;
			pwr_q     <= WKP_POWER_CFG_RST;
			pw_idx_q  <= 7'h00;
		end else begin
			if (wr_gl) glob_en_q <= hwdata[0];
			if (wr_en_r) en_q <= hwdata[WKP_NSRC-1:0];
			if (wr_km) kbms_q <= hwdata[7:0];
			if (wr_pc) pwr_q <= hwdata[7:0];
			if (wr_pi) pw_idx_q <= hwdata[6:0];
		end
	end

	// ----------------------------------------------------------------
	// Wake sources and status
	// ----------------------------------------------------------------
	logic [WKP_NSRC-1:0] src_prev_q, hit;
	logic                kb_hit, ms_hit;
	genvar g;
	generate
		for (g = 0; g < WKP_NSRC; g++) begin : g_src
			wire raw = (g == WKP_SRC_KBD) ? kb_hit :
				(g == WKP_SRC_MOUSE) ? ms_hit : (src_s[g] && !src_prev_q[g]);
			// In deep sleep only the first four sources stay armed.
			assign hit[g] = raw && (!deep_s || (g < WKP_NDEEP));
		end
	endgenerate

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			src_prev_q <= '0;
			stat_q     <= '0;
		end else begin
			src_prev_q <= src_s;
			// Set wins over a simultaneous write-one clear.
			stat_q <= (stat_q & ~(wr_st ? hwdata[WKP_NSRC-1:0] : '0)) | hit;
		end
	end
	assign irq              = |(stat_q & en_q);
	assign wake_event_out_n = !(glob_en_q && |(stat_q & en_q));

	// ----------------------------------------------------------------
	// Password storage and matching
	// ----------------------------------------------------------------
	logic [1:0] set_q;
	logic [3:0] pos_q;
	logic [7:0] mem_rd;
	wire  [6:0] set_base = (set_q == 2'd0) ? WKP_SET1_BASE :
		(set_q == 2'd1) ? WKP_SET2_BASE : WKP_SET3_BASE;
	wire  [6:0] match_addr = set_base | {3'b000, pos_q};
	wire  [6:0] rd_addr    = pd_take ? pw_idx_q : match_addr;

	wkp_pw_mem u_mem (
		.hclk  (hclk),
		.we    (wr_pd),
		.waddr (pw_idx_q),
		.wdata (hwdata[7:0]),
		.raddr (rd_addr),
		.rdata (mem_rd)
	);

	wire kb_on     = kbms_q[WKP_KB_EN_BIT];
	wire kb_any    = kbms_q[WKP_KB_ANY_BIT];
	// Stored sequence carries make and F0-break codes as plain bytes.
	wire byte_ok   = (kbd_byte == mem_rd);
	wire seq_end   = (mem_rd == WKP_PW_END) || (pos_q == WKP_SET_LAST);
	wire kb_go     = kb_on && kbd_valid && !rd_pd;
	wire pw_done   = (mem_rd == WKP_PW_END) && (pos_q != 4'h0) && !rd_pd;
	// Matching works one set at a time; any mismatched byte moves to the next set.
	// A completed match rewinds the position, so it signals for one cycle only.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			set_q <= 2'd0;
			pos_q <= 4'h0;
		end else if (kb_go && !kb_any) begin
			if (byte_ok && !seq_end) begin
				pos_q <= pos_q + 4'h1;
			end else begin
				pos_q <= 4'h0;
				if (!byte_ok) set_q <= (set_q == 2'd2) ? 2'd0 : set_q + 2'd1;
			end
		end else if (pw_done) begin
			pos_q <= 4'h0;
		end
	end
	wire kb_last = kb_go && !kb_any && byte_ok && (pos_q == WKP_SET_LAST);
	assign kb_hit = kb_on && ((kb_any && kbd_valid && kbd_byte != WKP_BREAK_PREFIX)
		|| (!kb_any && (pw_done || kb_last)));

	// ----------------------------------------------------------------
	// Mouse wake qualification
	// ----------------------------------------------------------------
	wire ms_on     = kbms_q[WKP_MS_EN_BIT];
	wire ms_motion = kbms_q[WKP_MS_MOTION_BIT];
	wire ms_single = kbms_q[WKP_MS_SINGLE_BIT];
	wire ms_right  = kbms_q[WKP_MS_RIGHT_BIT];
	wire left_c    = mouse_valid && (mouse_byte & WKP_MS_LEFT) != 8'h00;
	wire right_c   = mouse_valid && (mouse_byte & WKP_MS_RIGHT) != 8'h00;
	wire sel_c     = ms_right ? right_c : left_c;
	logic click2_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			click2_q <= 1'b0;
		end else if (ms_on && !ms_motion && !ms_single && sel_c) begin
			click2_q <= !click2_q;
		end
	end
	assign ms_hit = ms_on && (ms_motion ? (ms_single ? mouse_valid : (left_c || right_c))
		: (ms_single ? sel_c : (sel_c && click2_q)));

	// ----------------------------------------------------------------
	// Button output and wake pulse
	// ----------------------------------------------------------------
	wkp_pulse_t ps_q, ps_d;
	logic [7:0] cnt_q;
	wire        want = hit[WKP_SRC_KBD] || hit[WKP_SRC_MOUSE];
	always_comb begin
		ps_d = ps_q;
		case (ps_q)
			WKP_PS_IDLE:  if (want) ps_d = WKP_PS_PULSE;
			WKP_PS_PULSE: if (cnt_q == WKP_PULSE_CYC - 8'h01) ps_d = WKP_PS_IDLE;
			WKP_PS_HOLD:  ps_d = WKP_PS_IDLE;
			default:      ps_d = WKP_PS_IDLE;
		endcase
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ps_q  <= WKP_PS_IDLE;
			cnt_q <= 8'h00;
		end else begin
			ps_q  <= ps_d;
			cnt_q <= (ps_q == WKP_PS_PULSE) ? cnt_q + 8'h01 : 8'h00;
		end
	end
	assign button_out_n = btn_s_n && (ps_q != WKP_PS_PULSE);

	// ----------------------------------------------------------------
	// Power-loss restore
	// ----------------------------------------------------------------
	wire [1:0] policy = pwr_q[WKP_POLICY_LO+1:WKP_POLICY_LO];
	logic      restore_q;
	logic      pwr_on;
	always_comb begin
		case (policy)
			WKP_POL_OFF:  pwr_on = 1'b0;
			WKP_POL_ON:   pwr_on = 1'b1;
			WKP_POL_PREV: pwr_on = prev_on_q;
			WKP_POL_USER: pwr_on = !pwr_q[WKP_USER_OFF_BIT];
			default:      pwr_on = 1'b0;
		endcase
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prev_on_q   <= 1'b0;
			vcc_q       <= 1'b0;
			restore_q   <= 1'b1;
			supply_on_n <= 1'b1;
		end else begin
			vcc_q <= vcc_s;
			// Capture sleep S3 on the falling edge of the main supply.
			if (vcc_q && !vcc_s) prev_on_q <= s3_s_n;
			if (restore_q) begin
				supply_on_n <= !pwr_on;
				restore_q   <= 1'b0;
			end else if (!btn_s_n && !s3_s_n) begin
				supply_on_n <= 1'b0;
			end else begin
				supply_on_n <= !s3_s_n && supply_on_n ? 1'b1 : !s3_s_n;
			end
		end
	end

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (take && !hwrite) begin
			case (haddr[7:0])
				WKP_GLOBAL_EN_ADDR: hrdata <= {31'h0, glob_en_q};
				WKP_STATUS_ADDR:    hrdata <= {23'h0, stat_q};
				WKP_ENABLE_ADDR:    hrdata <= {23'h0, en_q};
				WKP_KBMS_CFG_ADDR:  hrdata <= {24'h0, kbms_q};
				WKP_POWER_CFG_ADDR: hrdata <= {24'h0, pwr_q};
				WKP_PW_INDEX_ADDR:  hrdata <= {25'h0, pw_idx_q};
				WKP_STATE_ADDR:     hrdata <= {28'h0, prev_on_q, supply_on_n, ps_q};
				default:            hrdata <= 32'h0000_0000;
			endcase
		end else if (rd_pd && !wait_q) begin
			hrdata <= {24'h0, mem_rd};
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	global_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!glob_en_q |-> wake_event_out_n) else $error("wake asserted while disabled");
	need_enable_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!wake_event_out_n |-> |(stat_q & en_q)) else $error("wake without source");
	sticky_stat_a: assert property (@(posedge hclk) disable iff (!hresetn)
		hit[0] |=> stat_q[0]) else $error("status not latched");
	button_follow_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!btn_s_n |-> !button_out_n) else $error("button not passed");
	pulse_len_a: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(ps_q == WKP_PS_PULSE) |-> (ps_q == WKP_PS_PULSE)[*8]) else $error("pulse short");
	pulse_start_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(want && ps_q == WKP_PS_IDLE) |=> ps_q == WKP_PS_PULSE) else $error("no pulse");
	kb_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!kb_on |-> !kb_hit) else $error("kbd wake while off");
	ms_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!ms_on |-> !ms_hit) else $error("mouse wake while off");
	deep_mask_a: assert property (@(posedge hclk) disable iff (!hresetn)
		deep_s |-> !(|hit[WKP_NSRC-1:WKP_NDEEP])) else $error("source active in deep sleep");
	wake_c: cover property (@(posedge hclk) disable iff (!hresetn) $fell(wake_event_out_n));
	pulse_c: cover property (@(posedge hclk) disable iff (!hresetn) $fell(button_out_n));
	pw_c: cover property (@(posedge hclk) disable iff (!hresetn) pw_done && kb_on);
endmodule : wkp_wake_ctrl

`default_nettype wire

// ---- wkp_pkg.sv ----
// Package of constants for the wake event and power control block.
`default_nettype none

package wkp_pkg;

	// --------------------------------------------------------------
	// Register byte addresses on the AHB-Lite slave
	// --------------------------------------------------------------
	localparam logic [7:0] WKP_GLOBAL_EN_ADDR = 8'h00;
	localparam logic [7:0] WKP_STATUS_ADDR    = 8'h04;
	localparam logic [7:0] WKP_ENABLE_ADDR    = 8'h08;
	localparam logic [7:0] WKP_KBMS_CFG_ADDR  = 8'h0C;
	localparam logic [7:0] WKP_POWER_CFG_ADDR = 8'h10;
	localparam logic [7:0] WKP_PW_INDEX_ADDR  = 8'h14;
	localparam logic [7:0] WKP_PW_DATA_ADDR   = 8'h18;
	localparam logic [7:0] WKP_STATE_ADDR     = 8'h1C;

	// --------------------------------------------------------------
	// Fields
	// --------------------------------------------------------------
	localparam int WKP_NSRC = 9;
	localparam int WKP_SRC_MOUSE = 0;
	localparam int WKP_SRC_KBD   = 1;
	localparam int WKP_SRC_GPIO  = 2;
	localparam int WKP_SRC_CIR   = 3;
	localparam int WKP_NDEEP     = 4;
	localparam int WKP_KB_ANY_BIT    = 0;
	localparam int WKP_MS_SINGLE_BIT = 1;
	localparam int WKP_MS_RIGHT_BIT  = 4;
	localparam int WKP_MS_EN_BIT     = 5;
	localparam int WKP_KB_EN_BIT     = 6;
	localparam int WKP_MS_MOTION_BIT = 7;
	localparam int WKP_USER_OFF_BIT  = 4;
	localparam int WKP_POLICY_LO     = 5;
	localparam logic [7:0] WKP_KBMS_CFG_RST  = 8'h01;
	localparam logic [7:0] WKP_POWER_CFG_RST = 8'h00;
	localparam logic [7:0] WKP_BREAK_PREFIX  = 8'hF0;
	localparam logic [7:0] WKP_PW_END        = 8'h00;
	localparam logic [1:0] WKP_POL_OFF  = 2'h0;
	localparam logic [1:0] WKP_POL_ON   = 2'h1;
	localparam logic [1:0] WKP_POL_PREV = 2'h2;
	localparam logic [1:0] WKP_POL_USER = 2'h3;
	localparam logic [6:0] WKP_SET1_BASE = 7'h00;
	localparam logic [6:0] WKP_SET2_BASE = 7'h30;
	localparam logic [6:0] WKP_SET3_BASE = 7'h40;
	localparam logic [3:0] WKP_SET_LAST  = 4'hE;
	localparam logic [7:0] WKP_MS_LEFT   = 8'h01;
	localparam logic [7:0] WKP_MS_RIGHT  = 8'h02;

	// --------------------------------------------------------------
	// Timing
	// --------------------------------------------------------------
	localparam int WKP_CLK_MHZ       = 10;
	localparam int WKP_PULSE_US      = 20;
	localparam int WKP_PULSE_CYC_I   = WKP_PULSE_US * WKP_CLK_MHZ;
	localparam logic [7:0] WKP_PULSE_CYC = WKP_PULSE_CYC_I[7:0];

	typedef enum logic [1:0] {
		WKP_PS_IDLE  = 2'b00,
		WKP_PS_PULSE = 2'b01,
		WKP_PS_HOLD  = 2'b10
	} wkp_pulse_t;

endpackage : wkp_pkg

`default_nettype wire

// ---- wkp_pw_mem.sv ----
// Password key code storage, 128 bytes with a registered read port.
`default_nettype none

module wkp_pw_mem
	import wkp_pkg::*;
(
	input  wire logic       hclk,
	input  wire logic       we,
	input  wire logic [6:0] waddr,
	input  wire logic [7:0] wdata,
	input  wire logic [6:0] raddr,
	output var  logic [7:0] rdata
);
	logic [7:0] mem [128];

	// No reset: storage contents are defined only once software writes them.
	always_ff @(posedge hclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule : wkp_pw_mem

`default_nettype wire

// ---- wkp_chipset_model.sv ----
// Behavioural model of the chipset and power supply facing the wake block.
`default_nettype none

module wkp_chipset_model (
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic button_out_n,
	input  wire logic supply_on_n,
	input  wire logic ac_ok,
	output var  logic sleep_s3_n,
	output wire logic main_supply_3v
);
	timeunit 1ns;
	timeprecision 1ns;

	// --------------------------------------------------------------
	// Chipset: a press of two cycles or more toggles the sleep state
	// --------------------------------------------------------------
	logic [3:0] low_q;

	// The toggle happens on release, as a real chipset debounces first.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			low_q      <= 4'h0;
			sleep_s3_n <= 1'b0;
		end else if (button_out_n === 1'b0) begin
			low_q <= (low_q == 4'hF) ? 4'hF : low_q + 4'h1;
		end else begin
			if (low_q >= 4'h2) begin
				sleep_s3_n <= ~sleep_s3_n;
			end
			low_q <= 4'h0;
		end
	end

	// --------------------------------------------------------------
	// Supply: main rail present only while switched on and mains is good
	// --------------------------------------------------------------
	assign main_supply_3v = ac_ok & (supply_on_n === 1'b0);

endmodule : wkp_chipset_model

`default_nettype wire

// ---- wkp_wake_ctrl_tb.sv ----
// Self-checking testbench for the wake event and power control block.
`default_nettype none

module wkp_wake_ctrl_tb
	import wkp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	typedef struct packed {
		logic [3:0] src;
		logic       gen;
		logic       en;
		logic       deep;
		logic       xstat;
		logic       xwake;
	} wkp_row_t;

	typedef struct packed {
		logic [7:0] cfg;
		logic [7:0] btn;
		logic [1:0] clicks;
	} wkp_mrow_t;

	logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic        kbd_valid = 1'b0, mouse_valid = 1'b0, deep_sleep = 1'b0;
	logic        button_in_n = 1'b1, ac_ok = 1'b1;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0;
	logic [7:0]  kbd_byte = 8'h00, mouse_byte = 8'h00;
	logic [8:0]  src_event = 9'h000;
	wire logic   hreadyout, hresp, button_out_n, supply_on_n, wake_event_out_n, irq;
	wire logic   sleep_s3_n, main_supply_3v;
	wire logic [31:0] hrdata;
	int          n_mismatch = 0, compares = 0, cycles = 0;
	logic [7:0]  pw [6] = '{8'h16, 8'hF0, 8'h16, 8'h1E, 8'hF0, 8'h1E};
	wkp_row_t    rows [10] = '{
		'{4'h2, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1}, '{4'h3, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1},
		'{4'h4, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1}, '{4'h5, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1},
		'{4'h6, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1}, '{4'h7, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1},
		'{4'h8, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1}, '{4'h8, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0},
		'{4'h2, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0}, '{4'h4, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0}};
	wkp_mrow_t   mrows [6] = '{'{8'hA3, 8'h00, 2'h0}, '{8'hA1, 8'h02, 2'h1},
		'{8'h23, 8'h01, 2'h1}, '{8'h33, 8'h02, 2'h1}, '{8'h21, 8'h01, 2'h2},
		'{8'h31, 8'h02, 2'h2}};

	always #50 hclk = ~hclk;

	wkp_wake_ctrl u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.src_event(src_event), .deep_sleep(deep_sleep), .kbd_valid(kbd_valid),
		.kbd_byte(kbd_byte), .mouse_valid(mouse_valid), .mouse_byte(mouse_byte),
		.button_in_n(button_in_n), .sleep_s3_n(sleep_s3_n),
		.main_supply_3v(main_supply_3v), .button_out_n(button_out_n),
		.supply_on_n(supply_on_n), .wake_event_out_n(wake_event_out_n), .irq(irq));

	wkp_chipset_model u_far (.hclk(hclk), .hresetn(hresetn), .button_out_n(button_out_n),
		.supply_on_n(supply_on_n), .ac_ok(ac_ok), .sleep_s3_n(sleep_s3_n),
		.main_supply_3v(main_supply_3v));

	// --------------------------------------------------------------
	// Tasks
	// --------------------------------------------------------------
	task automatic print_verdict();
		$display("compares %0d n_mismatch %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : print_verdict

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	// The wait loops rely on the global cycle ceiling to break a hang.
	task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge hclk);
		hsel   <= 1'b1;
		haddr  <= {24'h00_0000, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : ahb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] v;
		ahb(a, 1'b1, d, v);
	endtask : wr

	task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] v;
		ahb(a, 1'b0, 32'h0, v);
		chk(name, exp, v);
	endtask : rd_chk

	task automatic kb(input logic [7:0] b);
		@(posedge hclk);
		kbd_valid <= 1'b1;
		kbd_byte  <= b;
		@(posedge hclk);
		kbd_valid <= 1'b0;
	endtask : kb

	task automatic ms(input logic [7:0] b);
		@(posedge hclk);
		mouse_valid <= 1'b1;
		mouse_byte  <= b;
		@(posedge hclk);
		mouse_valid <= 1'b0;
	endtask : ms

	task automatic press(input int len);
		@(posedge hclk);
		button_in_n <= 1'b0;
		repeat (len) @(posedge hclk);
		button_in_n <= 1'b1;
	endtask : press

	task automatic exp_pulse(input string name, input int exp);
		int w;
		int n;
		w = 0;
		n = 0;
		while (button_out_n !== 1'b0 && w < 20) begin
			@(negedge hclk);
			w++;
		end
		while (button_out_n === 1'b0 && n < 400) begin
			@(negedge hclk);
			n++;
		end
		chk(name, exp, n);
	endtask : exp_pulse

	always @(posedge hclk) begin
		cycles++;
		if (cycles == 30000) begin
			n_mismatch++;
			$display("CHECK FAILED cycle ceiling expected end seen %0d", cycles);
			print_verdict();
		end
	end

	// --------------------------------------------------------------
	// Main sequence
	// --------------------------------------------------------------
	initial begin
		logic [31:0] v;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		rd_chk("global reset", WKP_GLOBAL_EN_ADDR, 32'h0);
		rd_chk("status reset", WKP_STATUS_ADDR, 32'h0);
		rd_chk("enable reset", WKP_ENABLE_ADDR, 32'h0);
		rd_chk("kbms reset", WKP_KBMS_CFG_ADDR, {24'h0, WKP_KBMS_CFG_RST});
		rd_chk("power reset", WKP_POWER_CFG_ADDR, {24'h0, WKP_POWER_CFG_RST});
		wr(8'h20, 32'hFFFF_FFFF);
		rd_chk("unmapped", 8'h20, 32'h0);
		rd_chk("global after unmapped", WKP_GLOBAL_EN_ADDR, 32'h0);
		chk("hresp", 32'h0, {31'h0, hresp});
		chk("supply off policy", 32'h1, {31'h0, supply_on_n});
		wr(WKP_POWER_CFG_ADDR, 32'h70);
		rd_chk("power cfg", WKP_POWER_CFG_ADDR, 32'h70);
		wr(WKP_POWER_CFG_ADDR, 32'h0);
		fork
			press(10);
			exp_pulse("button hold", 10);
		join
		repeat (10) @(posedge hclk);
		chk("supply follows s3", 32'h0, {31'h0, supply_on_n});
		ac_ok <= 1'b0;
		repeat (10) @(posedge hclk);
		ahb(WKP_STATE_ADDR, 1'b0, 32'h0, v);
		chk("previous on", 32'h1, {31'h0, v[3]});
		ac_ok <= 1'b1;
		press(10);
		repeat (12) @(posedge hclk);
		chk("supply off again", 32'h1, {31'h0, supply_on_n});
		ahb(WKP_STATE_ADDR, 1'b0, 32'h0, v);
		chk("previous off", 32'h0, {31'h0, v[3]});
		foreach (rows[i]) begin
			wr(WKP_STATUS_ADDR, 32'h1FF);
			wr(WKP_ENABLE_ADDR, {31'h0, rows[i].en} << rows[i].src);
			wr(WKP_GLOBAL_EN_ADDR, {31'h0, rows[i].gen});
			deep_sleep <= rows[i].deep;
			@(posedge hclk);
			src_event <= 9'h001 << rows[i].src;
			repeat (4) @(posedge hclk);
			src_event <= 9'h000;
			repeat (6) @(posedge hclk);
			ahb(WKP_STATUS_ADDR, 1'b0, 32'h0, v);
			chk("status bit", {31'h0, rows[i].xstat}, {31'h0, v[rows[i].src]});
			chk("wake out", {31'h0, ~rows[i].xwake}, {31'h0, wake_event_out_n});
			chk("irq", {31'h0, rows[i].xstat & rows[i].en}, {31'h0, irq});
			wr(WKP_STATUS_ADDR, 32'h1 << rows[i].src);
			rd_chk("status cleared", WKP_STATUS_ADDR, 32'h0);
		end
		deep_sleep <= 1'b0;
		wr(WKP_KBMS_CFG_ADDR, 32'h41);
		kb(8'h45);
		exp_pulse("any key pulse", WKP_PULSE_CYC_I);
		ahb(WKP_STATUS_ADDR, 1'b0, 32'h0, v);
		chk("kbd status", 32'h1, {31'h0, v[WKP_SRC_KBD]});
		wr(WKP_KBMS_CFG_ADDR, 32'h01);
		kb(8'h45);
		exp_pulse("kbd disabled", 0);
		// All three sets hold the same password, so set switching cannot hide a match.
		wr(WKP_KBMS_CFG_ADDR, 32'h40);
		for (int s = 0; s < 3; s++) begin
			for (int k = 0; k < 15; k++) begin
				wr(WKP_PW_INDEX_ADDR, {25'h0, (s == 0) ? WKP_SET1_BASE :
					(s == 1) ? WKP_SET2_BASE : WKP_SET3_BASE} + k);
				wr(WKP_PW_DATA_ADDR, (k < 6) ? {24'h0, pw[k]} : 32'h0);
			end
		end
		wr(WKP_PW_INDEX_ADDR, {25'h0, WKP_SET2_BASE} + 32'h1);
		rd_chk("password byte", WKP_PW_DATA_ADDR, {24'h0, WKP_BREAK_PREFIX});
		kb(8'h16);
		kb(8'hF0);
		kb(8'h33);
		exp_pulse("wrong password", 0);
		foreach (pw[k]) kb(pw[k]);
		exp_pulse("password pulse", WKP_PULSE_CYC_I);
		foreach (mrows[i]) begin
			wr(WKP_KBMS_CFG_ADDR, {24'h0, mrows[i].cfg});
			if (mrows[i].clicks == 2'h0) ms(mrows[i].btn);
			for (int c = 0; c < mrows[i].clicks; c++) begin
				if (c == 1) exp_pulse("first of two clicks", 0);
				ms(8'h00);
				ms(mrows[i].btn);
			end
			exp_pulse("mouse wake", WKP_PULSE_CYC_I);
		end
		wr(WKP_KBMS_CFG_ADDR, 32'h23);
		ms(8'h02);
		ms(8'h00);
		exp_pulse("right in left mode", 0);
		wr(WKP_KBMS_CFG_ADDR, 32'h83);
		ms(8'h01);
		exp_pulse("mouse disabled", 0);
		wr(WKP_ENABLE_ADDR, 32'h002);
		wr(WKP_GLOBAL_EN_ADDR, 32'h1);
		@(negedge hclk);
		chk("wake before reset", 32'h0, {31'h0, wake_event_out_n});
		@(posedge hclk);
		hresetn <= 1'b0;
		@(negedge hclk);
		chk("wake in reset", 32'h1, {31'h0, wake_event_out_n});
		chk("irq in reset", 32'h0, {31'h0, irq});
		chk("button in reset", 32'h1, {31'h0, button_out_n});
		chk("ready in reset", 32'h1, {31'h0, hreadyout});
		print_verdict();
	end

endmodule : wkp_wake_ctrl_tb

`default_nettype wire
